// file: hdl/acdpm_pkg.sv
// Purpose: Shared constants for the sample clock divider and power mode block.
// Assumes: A single system clock at 250 MHz and byte-wide control registers.
// Notes: Register addresses, field positions, reset values and timing counts live here.
package acdpm_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [8:0] ADDR_RESET_CTRL = 9'h008;
	localparam logic [8:0] ADDR_CAL_STATUS = 9'h107;
	localparam logic [8:0] ADDR_CLK_CTRL = 9'h009;
	localparam logic [8:0] ADDR_POWER_CTRL = 9'h00a;
	// Digital reset control: bit 0 starts a digital reset and self-clears.
	localparam int RST_BIT = 0;
	// Clock control: divide minus one in bits 2:0, stabilizer enable in bit 3.
	localparam int DIV_LSB = 0;
	localparam int DIV_MSB = 2;
	localparam int DCS_BIT = 3;
	localparam logic [7:0] CLK_CTRL_RESET = 8'h08;
	// Power control: bits 1:0 select normal, power-down or standby.
	localparam logic [1:0] PWR_NORMAL = 2'h0;
	localparam logic [1:0] PWR_DOWN = 2'h1;
	localparam logic [1:0] PWR_STANDBY = 2'h2;
	localparam logic [7:0] CAL_BUSY_CODE = 8'h01;
	localparam logic [7:0] CAL_DONE_CODE = 8'h00;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 250;
	localparam int CAL_TIME_US = 20;
	localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
	// Stabilizer lock is claimed only at or above this sample clock rate.
	localparam int DCS_MIN_MHZ = 20;
	// Stabilizer relock wait after a divide change, longest figure.
	localparam int DCS_RELOCK_NS = 5000;
	localparam int DCS_RELOCK_CYCLES = (DCS_RELOCK_NS * CLK_MHZ) / 1000;
endpackage

// file: hdl/acdpm_divider.sv
// Purpose: Integer divider producing a sample clock enable and a squared clock.
// Assumes: Divide value may be changed by the caller at any time, not only at reset.
// Notes: With the stabilizer on, high time is half the last measured divided period, rounded down.
`timescale 1ns/100ps
module acdpm_divider #(
	parameter int MAX_DIV = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_run,
	input wire logic [2:0] i_div_m1,
	input wire logic i_dcs_en,
	input wire logic i_clk_in,
	output logic o_sample,
	output logic o_int_clk
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic hi_q;
	logic hi_d;
	logic prev_q;
	logic prev_d;
	logic [15:0] per_q;
	logic [15:0] per_d;
	logic [15:0] len_q;
	logic [15:0] len_d;
	logic rise;
	logic fall;
	logic tick;
	// The period counter stops one short of all ones, so adding one to it never wraps.
	localparam logic [15:0] PER_MAX = 16'hfffe;

	initial begin
		if (MAX_DIV != 8) begin
			$error("acdpm_divider supports a maximum divide of 8 only");
		end
	end

	// ****************************************
	// Counting on rising input edges
	// ****************************************
	// A rising input edge at terminal count is one sample and starts a divided period.
	assign rise = i_clk_in && !prev_q;
	assign fall = !i_clk_in && prev_q;
	assign tick = i_run && rise && (cnt_q >= i_div_m1);

	// The stabilizer times the last divided period in system cycles and drops the clock halfway through it.
	// Counting input edges alone cannot give a half-period low for odd divides or a divide of one.
	always_comb begin
		prev_d = i_clk_in;
		cnt_d = cnt_q;
		hi_d = hi_q;
		per_d = per_q;
		len_d = len_q;
		if (!i_run) begin
			cnt_d = 3'h0;
			hi_d = 1'b0;
			per_d = 16'h0000;
			len_d = 16'h0000;
		end else begin
			if (per_q < PER_MAX) begin
				per_d = per_q + 16'h0001;
			end
			if (rise) begin
				cnt_d = (cnt_q >= i_div_m1) ? 3'h0 : 3'(cnt_q + 3'h1);
			end
			// Without the stabilizer the high time follows the raw input duty cycle.
			if (i_dcs_en) begin
				if ((per_q + 16'h0001) >= (len_q >> 1)) begin
					hi_d = 1'b0;
				end
			end else if (fall) begin
				hi_d = 1'b0;
			end
			// A new period wins over the falling edge of the one before.
			if (tick) begin
				hi_d = 1'b1;
				per_d = 16'h0000;
				len_d = per_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= 3'h0;
			hi_q <= 1'b0;
			prev_q <= 1'b0;
			per_q <= 16'h0000;
			len_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
			hi_q <= hi_d;
			prev_q <= prev_d;
			per_q <= per_d;
			len_q <= len_d;
		end
	end

	assign o_sample = tick;
	assign o_int_clk = hi_q;
endmodule

// file: hdl/acdpm_top.sv
// Purpose: Sample clock division, duty cycle stabilizer status, power modes and calibration.
// Assumes: i_clk_in is far slower than i_sys_clk; register bus is byte wide, one cycle access.
// Notes: Reads return data one cycle after the read strobe.
`timescale 1ns/100ps
module acdpm_top #(
	parameter int CAL_CYCLES = acdpm_pkg::CAL_CYCLES,
	parameter int RELOCK_CYCLES = acdpm_pkg::DCS_RELOCK_CYCLES,
	parameter int CLK_IN_MHZ = 125
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_clk_in,
	input wire logic i_spi_mode,
	input wire logic i_serial_data_powerdown_pin,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [8:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_sample,
	output logic o_int_clk,
	output logic o_dcs_locked,
	output logic o_out_drv_oe_n,
	output logic o_ref_on,
	output logic o_refbuf_on,
	output logic o_bias_on,
	output logic o_clk_on,
	output logic o_cal_busy
);
	typedef enum logic [2:0] {
		ST_CAL = 3'b001,
		ST_RUN = 3'b010,
		ST_OFF = 3'b100
	} acdpm_state_type;

	acdpm_state_type st_q;
	acdpm_state_type st_d;
	logic [31:0] cal_cnt_q;
	logic [31:0] cal_cnt_d;
	logic [31:0] lock_cnt_q;
	logic [31:0] lock_cnt_d;
	logic [7:0] clk_ctrl_q;
	logic [7:0] clk_ctrl_d;
	logic [1:0] pwr_q;
	logic [1:0] pwr_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [2:0] pin_sync_q;
	logic [2:0] clk_sync_q;
	logic pin_pd_q;
	logic pin_pd_d;
	logic reset_req;
	logic pd_req;
	logic stby;
	logic run;
	logic [2:0] div_m1;

	initial begin
		if (CAL_CYCLES < 2 || RELOCK_CYCLES < 2 || CLK_IN_MHZ < 1) begin
			$error("acdpm_top parameters out of range");
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Three stages; only the agreeing second and third stage decide a pin change.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_sync_q <= 3'h0;
			clk_sync_q <= 3'h0;
			pin_pd_q <= 1'b0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], i_serial_data_powerdown_pin};
			clk_sync_q <= {clk_sync_q[1:0], i_clk_in};
			pin_pd_q <= pin_pd_d;
		end
	end

	always_comb begin
		pin_pd_d = pin_pd_q;
		if (pin_sync_q[1] == pin_sync_q[2]) begin
			pin_pd_d = pin_sync_q[2];
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	// A digital reset is a one-cycle strobe; the register bit itself reads back zero.
	assign reset_req = i_wr && (i_addr == acdpm_pkg::ADDR_RESET_CTRL) && i_wdata[acdpm_pkg::RST_BIT];

	always_comb begin
		clk_ctrl_d = clk_ctrl_q;
		pwr_d = pwr_q;
		rdata_d = 8'h00;
		if (i_wr && i_addr == acdpm_pkg::ADDR_CLK_CTRL) begin
			clk_ctrl_d = i_wdata;
		end
		if (i_wr && i_addr == acdpm_pkg::ADDR_POWER_CTRL) begin
			pwr_d = i_wdata[1:0];
		end
		if (i_rd) begin
			case (i_addr)
				acdpm_pkg::ADDR_RESET_CTRL: rdata_d = 8'h00;
				acdpm_pkg::ADDR_CLK_CTRL: rdata_d = clk_ctrl_q;
				acdpm_pkg::ADDR_POWER_CTRL: rdata_d = {6'h00, pwr_q};
				acdpm_pkg::ADDR_CAL_STATUS: rdata_d = (st_q == ST_CAL) ? acdpm_pkg::CAL_BUSY_CODE
					: acdpm_pkg::CAL_DONE_CODE;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			clk_ctrl_q <= acdpm_pkg::CLK_CTRL_RESET;
			pwr_q <= acdpm_pkg::PWR_NORMAL;
			rdata_q <= 8'h00;
		end else begin
			clk_ctrl_q <= clk_ctrl_d;
			pwr_q <= pwr_d;
			rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// Power and calibration sequencer
	// ****************************************
	// sources of power-down
	assign pd_req = i_spi_mode ? (pwr_q == acdpm_pkg::PWR_DOWN) : pin_pd_q;
	assign stby = i_spi_mode && (pwr_q == acdpm_pkg::PWR_STANDBY);

	always_comb begin
		st_d = st_q;
		cal_cnt_d = cal_cnt_q;
		case (st_q)
			ST_CAL: begin
				// Standby during calibration is the host's fault; calibration still finishes first.
				cal_cnt_d = cal_cnt_q + 32'h1;
				if (cal_cnt_q >= 32'(CAL_CYCLES - 1)) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (reset_req) begin
					st_d = ST_CAL;
					cal_cnt_d = 32'h0;
				end else if (pd_req || stby) begin
					st_d = ST_OFF;
				end
			end
			ST_OFF: begin
				if (reset_req) begin
					st_d = ST_CAL;
					cal_cnt_d = 32'h0;
				end else if (!pd_req && !stby) begin
					st_d = ST_RUN;
				end
			end
			default: begin
				st_d = ST_CAL;
				cal_cnt_d = 32'h0;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q <= ST_CAL;
			cal_cnt_q <= 32'h0;
		end else begin
			st_q <= st_d;
			cal_cnt_q <= cal_cnt_d;
		end
	end

	assign run = (st_q != ST_OFF);
	assign o_out_drv_oe_n = !run;
	assign o_ref_on = run || stby;
	assign o_refbuf_on = run;
	assign o_bias_on = run;
	assign o_clk_on = run;
	assign o_cal_busy = (st_q == ST_CAL);
	assign o_rdata = rdata_q;

	// ****************************************
	// Divider and stabilizer lock
	// ****************************************
	assign div_m1 = clk_ctrl_q[acdpm_pkg::DIV_MSB:acdpm_pkg::DIV_LSB];

	acdpm_divider #(
		.MAX_DIV(8)
	) u_div (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_run(run),
		.i_div_m1(div_m1),
		.i_dcs_en(clk_ctrl_q[acdpm_pkg::DCS_BIT]),
		.i_clk_in(clk_sync_q[2]),
		.o_sample(o_sample),
		.o_int_clk(o_int_clk)
	);

	always_comb begin
		lock_cnt_d = lock_cnt_q;
		if (!run || !clk_ctrl_q[acdpm_pkg::DCS_BIT] || clk_ctrl_d != clk_ctrl_q
			|| (CLK_IN_MHZ / (32'(div_m1) + 1)) < acdpm_pkg::DCS_MIN_MHZ) begin
			lock_cnt_d = 32'h0;
		end else if (lock_cnt_q < 32'(RELOCK_CYCLES)) begin
			lock_cnt_d = lock_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lock_cnt_q <= 32'h0;
		end else begin
			lock_cnt_q <= lock_cnt_d;
		end
	end

	assign o_dcs_locked = (lock_cnt_q >= 32'(RELOCK_CYCLES));

	// ****************************************
	// Checks
	// ****************************************
	property p_cal_after_reset;
		@(posedge i_sys_clk) disable iff (!i_rstn) reset_req |=> o_cal_busy;
	endproperty
	a_cal_after_reset: assert property (p_cal_after_reset) else $error("reset did not start calibration");

	property p_status_busy;
		@(posedge i_sys_clk) disable iff (!i_rstn) (i_rd && i_addr == acdpm_pkg::ADDR_CAL_STATUS && o_cal_busy)
			|=> o_rdata != 8'h00;
	endproperty
	a_status_busy: assert property (p_status_busy) else $error("busy calibration read as zero");

	property p_status_done;
		@(posedge i_sys_clk) disable iff (!i_rstn) (i_rd && i_addr == acdpm_pkg::ADDR_CAL_STATUS && !o_cal_busy)
			|=> o_rdata == 8'h00;
	endproperty
	a_status_done: assert property (p_status_done) else $error("finished calibration read nonzero");

	property p_hiz_off;
		@(posedge i_sys_clk) disable iff (!i_rstn) !run |-> o_out_drv_oe_n && !o_clk_on && !o_bias_on;
	endproperty
	a_hiz_off: assert property (p_hiz_off) else $error("drivers or clock on in power-down");

	property p_pin_pd;
		@(posedge i_sys_clk) disable iff (!i_rstn) (!i_spi_mode && pin_pd_q && st_q == ST_RUN && !reset_req)
			|=> !o_refbuf_on;
	endproperty
	a_pin_pd: assert property (p_pin_pd) else $error("pin did not power down");

	property p_standby_ref;
		@(posedge i_sys_clk) disable iff (!i_rstn) stby |-> o_ref_on;
	endproperty
	a_standby_ref: assert property (p_standby_ref) else $error("reference off in standby");

	property p_no_sample_off;
		@(posedge i_sys_clk) disable iff (!i_rstn) !run |-> !o_sample;
	endproperty
	a_no_sample_off: assert property (p_no_sample_off) else $error("sample produced in power-down");

	property p_lock_drop;
		@(posedge i_sys_clk) disable iff (!i_rstn) (clk_ctrl_d != clk_ctrl_q) |=> !o_dcs_locked;
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock kept across rate change");
endmodule

// file: sim/acdpm_clk_source.sv
// Purpose: Model of the external sample clock source.
// Assumes: Half periods in ns are set by the bench and may change at any time.
// Notes: Runs free, offset 1 ns from the system clock grid so its edges fall between system clock edges.
`timescale 1ns/100ps
module acdpm_clk_source (
	input wire logic [7:0] i_high_ns,
	input wire logic [7:0] i_low_ns,
	output logic o_clk
);
	// Half periods are read afresh, so a rate change takes hold at the next edge.
	initial begin
		o_clk = 1'b0;
		#1;
		forever begin
			o_clk = 1'b1;
			#(i_high_ns);
			o_clk = 1'b0;
			#(i_low_ns);
		end
	end
endmodule

// file: sim/test_adc_clock_divider_power_modes.sv
// Purpose: Self-checking bench for the divider, stabilizer and power modes.
// Assumes: Short calibration and relock counts.
// Notes: Inputs change on the falling edge; integer model gives expectations.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_adc_clock_divider_power_modes;
	localparam int CAL = 10;
	localparam int RELOCK = 8;
	localparam int IN_MHZ = 125;
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_spi_mode = 1'b0;
	logic i_pin = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [8:0] i_addr = 9'h000;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata, rd_val;
	logic clk_in, o_sample, o_int_clk, o_dcs_locked, oe_n, ref_on, refbuf_on, bias_on, clk_on, o_cal_busy;
	wire [4:0] pwr = {oe_n, ref_on, refbuf_on, bias_on, clk_on};
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int edges = 0;
	int samples = 0;
	int hi = 0;
	int tot = 0;
	int start, div;
	// ****
	// Clock, source and design
	// ****
	always #2 i_sys_clk = ~i_sys_clk;
	acdpm_clk_source src (.i_high_ns(8'd12), .i_low_ns(8'd28), .o_clk(clk_in));
	acdpm_top #(.CAL_CYCLES(CAL), .RELOCK_CYCLES(RELOCK), .CLK_IN_MHZ(IN_MHZ)) dut (.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn), .i_clk_in(clk_in), .i_spi_mode(i_spi_mode), .i_serial_data_powerdown_pin(i_pin),
		.i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_sample(o_sample),
		.o_int_clk(o_int_clk), .o_dcs_locked(o_dcs_locked), .o_out_drv_oe_n(oe_n), .o_ref_on(ref_on),
		.o_refbuf_on(refbuf_on), .o_bias_on(bias_on), .o_clk_on(clk_on), .o_cal_busy(o_cal_busy));
	// Input edges, sample pulses and high time feed the model; a hang is cut off.
	// Outputs are counted at the falling edge, where they have settled after the rising edge.
	always @(posedge clk_in) edges++;
	always @(negedge i_sys_clk) begin
		cycles++;
		samples += int'(o_sample === 1'b1);
		hi += int'(o_int_clk === 1'b1);
		tot++;
		if (cycles == 40000) begin
			errors++;
			test_done();
		end
	end
	// ****
	// Tasks and model
	// ****
	task automatic test_done();
		if (errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(negedge i_sys_clk);
		i_wr = 1'b1;
		i_addr = a;
		i_wdata = d;
		@(negedge i_sys_clk);
		i_wr = 1'b0;
	endtask
	// Read data stands for the one cycle after the strobe, so it is taken then.
	task automatic rd(input logic [8:0] a);
		@(negedge i_sys_clk);
		i_rd = 1'b1;
		i_addr = a;
		@(negedge i_sys_clk);
		i_rd = 1'b0;
		rd_val = o_rdata;
	endtask
	function automatic logic [4:0] pwr_exp(input int m);
		return (m == 0) ? 5'h0f : (m == 1) ? 5'h10 : 5'h18;
	endfunction
	// Sample pulses over 16 divided periods; sync latency allows one either way.
	task automatic measure(input int d);
		int k;
		k = 0;
		edges = 0;
		samples = 0;
		hi = 0;
		tot = 0;
		while (edges < 16 * d && k < 5000) begin
			idle(1);
			k++;
		end
		`CHK("input edges seen", 1'b1, edges >= 16 * d)
		`CHK("sample count", 1'b1, samples >= 15 && samples <= 17)
		`CHK("duty near half", 1'b1, hi * 100 >= tot * 40 && hi * 100 <= tot * 60)
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		void'($urandom(58299));
		idle(6);
		i_rstn = 1'b1;
		rd(acdpm_pkg::ADDR_CAL_STATUS);
		`CHK("cal status busy", acdpm_pkg::CAL_BUSY_CODE, rd_val)
		`CHK("cal busy flag", 1'b1, o_cal_busy)
		idle(CAL + 4);
		rd(acdpm_pkg::ADDR_CAL_STATUS);
		`CHK("cal status done", acdpm_pkg::CAL_DONE_CODE, rd_val)
		rd(acdpm_pkg::ADDR_CLK_CTRL);
		`CHK("clock ctrl reset", acdpm_pkg::CLK_CTRL_RESET, rd_val)
		wr(9'h1ff, 8'($urandom));
		rd(9'h1ff);
		`CHK("unmapped read", 8'h00, rd_val)
		wr(acdpm_pkg::ADDR_CAL_STATUS, 8'hff);
		rd(acdpm_pkg::ADDR_CAL_STATUS);
		`CHK("status read only", acdpm_pkg::CAL_DONE_CODE, rd_val)
		start = $urandom % 8;
		for (int k = 0; k < 8; k++) begin
			div = (start + k) % 8 + 1;
			wr(acdpm_pkg::ADDR_CLK_CTRL, 8'(div - 1) | 8'h08);
			idle(RELOCK + 20);
			rd(acdpm_pkg::ADDR_CLK_CTRL);
			`CHK("clock ctrl", 8'(div - 1) | 8'h08, rd_val)
			`CHK("lock by rate", IN_MHZ / div >= 20, o_dcs_locked)
			measure(div);
		end
		wr(acdpm_pkg::ADDR_CLK_CTRL, 8'h00);
		idle(RELOCK + 20);
		`CHK("lock with stabilizer off", 1'b0, o_dcs_locked)
		i_pin = 1'b1;
		idle(12);
		`CHK("pin power-down", pwr_exp(1), pwr)
		i_pin = 1'b0;
		idle(12);
		`CHK("pin wake", pwr_exp(0), pwr)
		i_spi_mode = 1'b1;
		i_pin = 1'b1;
		idle(12);
		`CHK("pin ignored in serial mode", pwr_exp(0), pwr)
		i_pin = 1'b0;
		for (int m = 1; m < 4; m++) begin
			wr(acdpm_pkg::ADDR_POWER_CTRL, 8'(m % 3));
			idle(4);
			`CHK("register power mode", pwr_exp(m % 3), pwr)
		end
		wr(acdpm_pkg::ADDR_RESET_CTRL, 8'h01);
		idle(1);
		`CHK("cal after reset", 1'b1, o_cal_busy)
		rd(acdpm_pkg::ADDR_RESET_CTRL);
		`CHK("reset bit clears", 8'h00, rd_val)
		rd(acdpm_pkg::ADDR_CAL_STATUS);
		`CHK("status busy again", acdpm_pkg::CAL_BUSY_CODE, rd_val)
		idle(CAL + 4);
		rd(acdpm_pkg::ADDR_CAL_STATUS);
		`CHK("status done again", acdpm_pkg::CAL_DONE_CODE, rd_val)
		wr(acdpm_pkg::ADDR_POWER_CTRL, 8'h02);
		idle(4);
		`CHK("standby after reset", pwr_exp(2), pwr)
		test_done();
	end
endmodule
